// [logic/tx_pkg.sv]
package tx_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 6;
  localparam logic [5:0] CMD_OFS = 6'h00;
  localparam logic [5:0] INTC_OFS = 6'h04;
  localparam logic [5:0] RXC_OFS = 6'h0C;
  localparam logic [5:0] MODE_OFS = 6'h10;
  localparam logic [5:0] TXCTL_OFS = 6'h14;
  localparam logic [5:0] SYNL_OFS = 6'h18;
  localparam logic [5:0] SYNH_OFS = 6'h1C;
  localparam logic [5:0] DATA_OFS = 6'h20;
  localparam logic [5:0] STAT_OFS = 6'h24;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic EOM_RST = 1'b1;
  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int CMD_LSB = 3;
  localparam int CRCCMD_LSB = 6;
  localparam logic [2:0] CMD_RST_EXT = 3'h2;
  localparam logic [2:0] CMD_CHAN_RST = 3'h3;
  localparam logic [2:0] CMD_RST_TXP = 3'h5;
  localparam logic [1:0] CRCCMD_RST_TX = 2'h2;
  localparam logic [1:0] CRCCMD_RST_EOM = 2'h3;
  localparam int EXT_IE = 0;
  localparam int TX_IE = 1;
  localparam int WR_FUNC = 6;
  localparam int WR_EN = 7;
  localparam int AUTO_EN = 5;
  localparam int PAR_EN = 0;
  localparam int PAR_EVEN = 1;
  localparam int SYNC_LSB = 4;
  localparam logic [1:0] SYNC_16 = 2'h1;
  localparam logic [1:0] SYNC_FRAME = 2'h2;
  localparam int CRC_EN = 0;
  localparam int RTS_ON = 1;
  localparam int CRC16_SEL = 2;
  localparam int TX_EN = 3;
  localparam int SEND_BRK = 4;
  localparam int LEN_LSB = 5;
  localparam int DTR_ON = 7;
  localparam int ST_INT = 1;
  localparam int ST_TBE = 2;
  localparam int ST_CTS = 5;
  localparam int ST_EOM = 6;
  localparam logic [15:0] POLY_CRC16 = 16'h8005;
  localparam logic [15:0] POLY_FRAME = 16'h1021;
  localparam logic [15:0] CRC_ONES = 16'hFFFF;
  localparam logic [15:0] CRC_ZERO = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ST_MARK, ST_SHIFT} tx_state_t;
endpackage

// [logic/crc_if.sv]
`timescale 1ns/100ps
interface crc_if;
  logic clear;
  logic init_ones;
  logic step;
  logic din;
  logic sel16;
  logic [15:0] value;
  modport gen (input clear, init_ones, step, din, sel16, output value);
  modport user (output clear, init_ones, step, din, sel16, input value);
endinterface

// [logic/crc_gen.sv]
`timescale 1ns/100ps
module crc_gen import tx_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  crc_if.gen c
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  wire fb = c.din ^ crc_q[15];
  wire [15:0] poly = c.sel16 ? POLY_CRC16 : POLY_FRAME;
  wire [15:0] init = c.init_ones ? CRC_ONES : CRC_ZERO;
  wire [15:0] shifted = {crc_q[14:0], 1'b0} ^ (fb ? poly : CRC_ZERO);

  assign crc_d = c.clear ? init : (c.step ? shifted : crc_q);
  assign c.value = crc_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= CRC_ZERO;
    end else begin
      crc_q <= crc_d;
    end
  end
endmodule

// [logic/link_sync.sv]
`timescale 1ns/100ps
module link_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic txc_pin,
  input wire logic cts_n_pin,
  output logic tick,
  output logic cts_on
);
  // ****************************************
  // two-stage pin synchronisers
  // ****************************************
  logic txc_s1_q;
  logic txc_s2_q;
  logic txc_s3_q;
  logic cts_s1_q;
  logic cts_s2_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_s1_q <= 1'b1;
      txc_s2_q <= 1'b1;
      txc_s3_q <= 1'b1;
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
    end else begin
      txc_s1_q <= txc_pin;
      txc_s2_q <= txc_s1_q;
      txc_s3_q <= txc_s2_q;
      cts_s1_q <= cts_n_pin;
      cts_s2_q <= cts_s1_q;
    end
  end

  // line data changes on the falling edge of the link clock
  assign tick = txc_s3_q & ~txc_s2_q;
  assign cts_on = ~cts_s2_q;
endmodule

// [logic/tx_channel.sv]
// Contract
// - transmit CRC uses selectable CRC-16 or frame polynomial.
// - outside frame mode the CRC generator clears to all zeros.
// - reset-transmit-CRC command reinitializes the transmit CRC generator.
// - external/status interrupt watches clear-to-send and underrun/EOM latch.
// - with auto enable, transmitter runs only while clear-to-send active.
// - line held marking after reset and while transmitter disabled.
// - send break drives spacing at once, no character boundary wait.
// - enabled with no data, sync character 8 or 16 bits repeats.
// - transmit interrupt enable raises pending when buffer goes empty.
// - new character or reset-pending command clears transmit pending.
// - after command clear with no write, no further empty interrupt.
// - wait mode asserts wait/ready while the buffer cannot accept.
// - ready mode asserts wait/ready when buffer empty and accepting.
// - shifter empty with no new character means transmit underrun.
// - underrun/EOM status shows sync filling or CRC being sent.
// - underrun/EOM latch is set after chip or channel reset.
// - after latch reset, next underrun sends CRC then syncs.
// - data and sync characters leave least significant bit first; CRC leaves most significant bit first.
`timescale 1ns/100ps
module tx_channel import tx_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic TXC,
  input wire logic CTS_N,
  output logic TXD,
  output logic RTS_N,
  output logic DTR_N,
  output logic WAIT_READY_N,
  output logic INT_N
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [3:0] char_len(input logic [1:0] code);
    case (code)
      2'h0: char_len = 4'h5;
      2'h1: char_len = 4'h7;
      2'h2: char_len = 4'h6;
      default: char_len = 4'h8;
    endcase
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = v[15-i];
    end
  endfunction

  function automatic logic is_map(input logic [ADDR_W-1:0] a);
    is_map = (a == CMD_OFS) || (a == INTC_OFS) || (a == RXC_OFS) ||
             (a == MODE_OFS) || (a == TXCTL_OFS) || (a == SYNL_OFS) ||
             (a == SYNH_OFS) || (a == DATA_OFS) || (a == STAT_OFS);
  endfunction

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_ok_q;
  logic w_ok_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_mux;

  assign AWREADY = ~aw_ok_q & ~bvalid_q;
  assign WREADY = ~w_ok_q & ~bvalid_q;
  assign ARREADY = ~rvalid_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  wire wr_fire = aw_ok_q & w_ok_q & ~bvalid_q;
  wire rd_fire = ARVALID & ~rvalid_q;
  // status is read-only, so a write to it is refused
  wire wr_good = is_map(waddr_q) && (waddr_q != STAT_OFS);
  wire wr_en = wr_fire & wr_good & wlane_q;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= REG_RST;
      wlane_q <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_ok_q <= 1'b1;
        waddr_q <= AWADDR;
      end else if (wr_fire) begin
        aw_ok_q <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_ok_q <= 1'b1;
        wdata_q <= WDATA[7:0];
        wlane_q <= WSTRB[0];
      end else if (wr_fire) begin
        w_ok_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_good ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_mux};
      rresp_q <= is_map(ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // write strobes and commands
  // ****************************************
  wire we_cmd = wr_en && (waddr_q == CMD_OFS);
  wire we_intc = wr_en && (waddr_q == INTC_OFS);
  wire we_rxc = wr_en && (waddr_q == RXC_OFS);
  wire we_mode = wr_en && (waddr_q == MODE_OFS);
  wire we_txctl = wr_en && (waddr_q == TXCTL_OFS);
  wire we_synl = wr_en && (waddr_q == SYNL_OFS);
  wire we_synh = wr_en && (waddr_q == SYNH_OFS);
  wire we_data = wr_en && (waddr_q == DATA_OFS);
  wire [2:0] cmd = wdata_q[CMD_LSB +: 3];
  wire [1:0] crc_cmd = wdata_q[CRCCMD_LSB +: 2];
  wire chan_rst = we_cmd && (cmd == CMD_CHAN_RST);
  wire rst_ext = we_cmd && (cmd == CMD_RST_EXT);
  wire rst_txp = we_cmd && (cmd == CMD_RST_TXP);
  wire rst_crc = we_cmd && (crc_cmd == CRCCMD_RST_TX);
  wire rst_eom = we_cmd && (crc_cmd == CRCCMD_RST_EOM);

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] intc_q;
  logic [7:0] rxc_q;
  logic [7:0] mode_q;
  logic [7:0] txctl_q;
  logic [7:0] synl_q;
  logic [7:0] synh_q;

  // a channel reset command returns the setup to its reset values
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      intc_q <= REG_RST;
      rxc_q <= REG_RST;
      mode_q <= REG_RST;
      txctl_q <= REG_RST;
      synl_q <= REG_RST;
      synh_q <= REG_RST;
    end else if (chan_rst) begin
      intc_q <= REG_RST;
      rxc_q <= REG_RST;
      mode_q <= REG_RST;
      txctl_q <= REG_RST;
      synl_q <= REG_RST;
      synh_q <= REG_RST;
    end else begin
      if (we_intc) intc_q <= wdata_q;
      if (we_rxc) rxc_q <= wdata_q;
      if (we_mode) mode_q <= wdata_q;
      if (we_txctl) txctl_q <= wdata_q;
      if (we_synl) synl_q <= wdata_q;
      if (we_synh) synh_q <= wdata_q;
    end
  end

  // ****************************************
  // link pins and CRC generator
  // ****************************************
  logic tick;
  logic cts_on;
  crc_if crc ();

  link_sync u_sync (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .txc_pin(TXC),
    .cts_n_pin(CTS_N),
    .tick(tick),
    .cts_on(cts_on)
  );

  crc_gen u_crc (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .c(crc)
  );

  // ****************************************
  // character selection
  // ****************************************
  tx_state_t state_q;
  logic [15:0] sh_q;
  logic [4:0] cnt_q;
  logic [3:0] cb_q;
  logic txd_q;
  logic [7:0] buf_q;
  logic buf_full_q;
  logic eom_q;
  logic txp_q;
  logic extp_q;
  logic cts_prev_q;

  wire tx_on = txctl_q[TX_EN] & (~rxc_q[AUTO_EN] | cts_on);
  wire brk = txctl_q[SEND_BRK];
  wire [3:0] len = char_len(txctl_q[LEN_LSB +: 2]);
  wire par_en = mode_q[PAR_EN];
  wire sync16 = mode_q[SYNC_LSB +: 2] == SYNC_16;
  wire [7:0] len_mask = 8'(9'h0FF >> (4'h8 - len));
  wire [7:0] data_m = buf_q & len_mask;
  wire par_bit = ^data_m ^ ~mode_q[PAR_EVEN];
  wire [15:0] par_w = par_en ? 16'(16'h0001 << len) : 16'h0000;
  wire [15:0] data_w = {8'h00, data_m} | (par_bit ? par_w : 16'h0000);
  wire [15:0] sync_w = sync16 ? {synh_q, synl_q} : {8'h00, synl_q};

  wire slot = (state_q == ST_MARK) || (cnt_q == 5'h00);
  wire ld_go = tick & tx_on & ~brk & slot;
  wire ld_data = ld_go & buf_full_q;
  // shifter ran dry with no new character
  wire underrun = ld_go & ~buf_full_q;
  wire ld_crc = underrun & ~eom_q;
  wire sh_go = tick & ~brk & (state_q == ST_SHIFT) & (cnt_q != 5'h00);
  wire stop = tick & (state_q == ST_SHIFT) & (cnt_q == 5'h00) & ~tx_on;

  logic [15:0] ld_word;
  logic [4:0] ld_cnt;
  always_comb begin
    if (ld_data) begin
      ld_word = data_w;
      ld_cnt = {1'b0, len} + {4'h0, par_en};
    end else if (ld_crc) begin
      ld_word = rev16(crc.value);
      ld_cnt = 5'h10;
    end else begin
      ld_word = sync_w;
      ld_cnt = sync16 ? 5'h10 : 5'h08;
    end
  end

  // ****************************************
  // CRC control
  // ****************************************
  // command clears generator
  assign crc.clear = rst_crc | chan_rst | ld_crc;
  assign crc.init_ones = mode_q[SYNC_LSB +: 2] == SYNC_FRAME;
  assign crc.sel16 = txctl_q[CRC16_SEL];
  // data bits only: syncs, parity and CRC are never accumulated
  assign crc.step = (ld_data & txctl_q[CRC_EN]) | (sh_go & (cb_q != 4'h0));
  assign crc.din = ld_data ? ld_word[0] : sh_q[0];

  // ****************************************
  // shifter
  // ****************************************
  // break drops both characters
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_MARK;
      sh_q <= '0;
      cnt_q <= '0;
      cb_q <= '0;
      txd_q <= 1'b1;
    end else if (chan_rst || brk) begin
      state_q <= ST_MARK;
      cnt_q <= '0;
      cb_q <= '0;
      txd_q <= 1'b1;
    end else begin
      case (state_q)
        ST_MARK: begin
          if (ld_go) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (stop) begin
            state_q <= ST_MARK;
          end
        end
        default: begin
          state_q <= ST_MARK;
        end
      endcase
      if (ld_go) begin
        txd_q <= ld_word[0];
        sh_q <= ld_word >> 1;
        cnt_q <= ld_cnt - 5'h01;
        cb_q <= (ld_data && txctl_q[CRC_EN]) ? len - 4'h1 : 4'h0;
      end else if (sh_go) begin
        txd_q <= sh_q[0];
        sh_q <= sh_q >> 1;
        cnt_q <= cnt_q - 5'h01;
        cb_q <= (cb_q != 4'h0) ? cb_q - 4'h1 : 4'h0;
      end else if (stop) begin
        txd_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // buffer and status latches
  // ****************************************
  // a write in the same cycle as a load keeps the new character
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      buf_q <= REG_RST;
      buf_full_q <= 1'b0;
    end else if (we_data) begin
      buf_q <= wdata_q;
      buf_full_q <= 1'b1;
    end else if (ld_data || brk || chan_rst) begin
      buf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      eom_q <= EOM_RST;
    end else if (ld_crc || chan_rst) begin
      eom_q <= 1'b1;
    end else if (rst_eom) begin
      eom_q <= 1'b0;
    end
  end

  // only a load can set it, so an empty buffer stays quiet
  wire txp_set = ld_data & intc_q[TX_IE];
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      txp_q <= 1'b0;
    end else if (txp_set) begin
      txp_q <= 1'b1;
    end else if (we_data || rst_txp || chan_rst) begin
      txp_q <= 1'b0;
    end
  end

  wire ext_evt = (cts_on != cts_prev_q) | (ld_crc & ~eom_q);
  wire extp_set = ext_evt & intc_q[EXT_IE];
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      extp_q <= 1'b0;
      cts_prev_q <= 1'b0;
    end else begin
      cts_prev_q <= cts_on;
      if (extp_set) begin
        extp_q <= 1'b1;
      end else if (rst_ext || chan_rst) begin
        extp_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // outputs and status read
  // ****************************************
  wire int_any = (txp_q & intc_q[TX_IE]) | (extp_q & intc_q[EXT_IE]);
  wire wait_on = ~intc_q[WR_FUNC] & buf_full_q;
  wire ready_on = intc_q[WR_FUNC] & ~buf_full_q & tx_on;

  assign TXD = txd_q & ~brk;
  assign RTS_N = ~txctl_q[RTS_ON];
  assign DTR_N = ~txctl_q[DTR_ON];
  assign INT_N = ~int_any;
  assign WAIT_READY_N = ~(intc_q[WR_EN] & (wait_on | ready_on));

  // latch shows sync fill or CRC
  logic [7:0] stat;
  always_comb begin
    stat = 8'h00;
    stat[ST_INT] = int_any;
    stat[ST_TBE] = ~buf_full_q;
    stat[ST_CTS] = cts_on;
    stat[ST_EOM] = eom_q;
  end

  always_comb begin
    case (ARADDR)
      INTC_OFS: rd_mux = intc_q;
      RXC_OFS: rd_mux = rxc_q;
      MODE_OFS: rd_mux = mode_q;
      TXCTL_OFS: rd_mux = txctl_q;
      SYNL_OFS: rd_mux = synl_q;
      SYNH_OFS: rd_mux = synh_q;
      STAT_OFS: rd_mux = stat;
      default: rd_mux = 8'h00;
    endcase
  end
endmodule

// [testbench/tx_channel_checker.sv]
`timescale 1ns/100ps
module tx_channel_checker import tx_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic TXD,
  input wire logic RTS_N,
  input wire logic DTR_N,
  input wire logic WAIT_READY_N,
  input wire logic INT_N
);
  // ****************************************
  // shadow of the control registers
  // ****************************************
  logic aw_q, w_q, ws_q, seen_q;
  logic [ADDR_W-1:0] ad_q;
  logic [7:0] wd_q, ctl_q, intc_q;
  wire aw_hs = AWVALID && AWREADY;
  wire w_hs = WVALID && WREADY;
  wire both = aw_q && w_q;
  // shadow lands on the same edge as the design's own register
  wire ctl_wr = both && ws_q && ad_q == TXCTL_OFS;
  wire intc_wr = both && ws_q && ad_q == INTC_OFS;
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {aw_q, w_q, ws_q, seen_q, ad_q, wd_q, ctl_q, intc_q} <= '0;
    end else begin
      aw_q <= aw_hs || (aw_q && !both);
      w_q <= w_hs || (w_q && !both);
      ad_q <= aw_hs ? AWADDR : ad_q;
      {ws_q, wd_q} <= w_hs ? {WSTRB[0], WDATA[7:0]} : {ws_q, wd_q};
      ctl_q <= ctl_wr ? wd_q : ctl_q;
      intc_q <= intc_wr ? wd_q : intc_q;
      seen_q <= seen_q || ctl_q[TX_EN];
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  property p_write_answer; both |=> BVALID; endproperty
  a_write_answer: assert property (p_write_answer) else $error("no bvalid");
  property p_read_answer; ARVALID && ARREADY |=> RVALID; endproperty
  a_read_answer: assert property (p_read_answer) else $error("no rvalid");
  property p_bhold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
  property p_rhold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_rhold: assert property (p_rhold) else $error("rdata dropped");
  property p_idle_mark; !seen_q && !ctl_q[SEND_BRK] |-> TXD; endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("line not mark");
  property p_break; ctl_q[SEND_BRK] && $past(ctl_q[SEND_BRK]) |-> !TXD;
  endproperty
  a_break: assert property (p_break) else $error("break not spacing");
  property p_int_gate; !INT_N |-> intc_q[TX_IE] || intc_q[EXT_IE]; endproperty
  a_int_gate: assert property (p_int_gate) else $error("int unmasked");
  property p_wait_gate; !WAIT_READY_N |-> intc_q[WR_EN]; endproperty
  a_wait_gate: assert property (p_wait_gate) else $error("wait/ready off");
  property p_ready_en; !WAIT_READY_N && intc_q[WR_FUNC] |-> ctl_q[TX_EN];
  endproperty
  a_ready_en: assert property (p_ready_en) else $error("ready while off");
  property p_modem; RTS_N == !ctl_q[RTS_ON] && DTR_N == !ctl_q[DTR_ON];
  endproperty
  a_modem: assert property (p_modem) else $error("modem outputs wrong");
endmodule

bind tx_channel tx_channel_checker chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
  .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .TXD(TXD),
  .RTS_N(RTS_N), .DTR_N(DTR_N), .WAIT_READY_N(WAIT_READY_N), .INT_N(INT_N));

// [testbench/line_partner.sv]
`timescale 1ns/100ps
module line_partner (
  input wire logic txd,
  input wire logic run,
  input wire logic cts_on,
  output logic txc,
  output logic cts_n,
  output logic [63:0] cap
);
  // ****************************************
  // modem side: transmit clock and capture
  // ****************************************
  // clock parks high when the line is not running
  initial begin
    txc = 1'b1;
    forever begin
      #160;
      if (run || !txc) txc = ~txc;
    end
  end
  assign cts_n = !cts_on;
  // sample late in the cell, just before the next shift; first bit ends lowest
  always @(negedge txc) cap <= {txd, cap[63:1]};
endmodule

// [testbench/tb_tx_channel.sv]
`timescale 1ns/100ps
module tb_tx_channel import tx_pkg::*;;
  logic REF_CLK, RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0] WSTRB, ws;
  logic [1:0] BRESP, RRESP, rs;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TXC, CTS_N, TXD;
  logic RTS_N, DTR_N, WAIT_READY_N, INT_N, run, cts_on;
  logic [63:0] cap;
  logic [15:0] cr;
  int errors, compares, cycles, k;
  tx_channel uut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .TXC(TXC), .CTS_N(CTS_N), .TXD(TXD), .RTS_N(RTS_N),
    .DTR_N(DTR_N), .WAIT_READY_N(WAIT_READY_N), .INT_N(INT_N));
  line_partner far_end (.txd(TXD), .run(run), .cts_on(cts_on), .txc(TXC),
    .cts_n(CTS_N), .cap(cap));
  // ****************************************
  // bus tasks and helpers
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobe off also delays bready, so the hold-until-ready path is used
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bit got;
    got = 0;
    @(posedge REF_CLK);
    AWADDR <= a;
    WDATA <= {24'h000000, d};
    WSTRB <= ws;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= ws[0];
    while (!got) begin
      @(posedge REF_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) begin
        got = 1;
        rs = BRESP;
        BREADY <= 1'b0;
      end else if (BVALID) BREADY <= 1'b1;
    end
  endtask
  task automatic rdt(input logic [5:0] a);
    bit got;
    got = 0;
    @(posedge REF_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= ws[0];
    while (!got) begin
      @(posedge REF_CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) begin
        got = 1;
        rd = RDATA;
        rs = RRESP;
        RREADY <= 1'b0;
      end else if (RVALID) RREADY <= 1'b1;
    end
  endtask
  task automatic bits(input int n);
    repeat (n) @(negedge TXC);
    @(posedge REF_CLK);
  endtask
  task automatic poll_int;
    repeat (600) begin
      @(posedge REF_CLK);
      if (INT_N === 1'b0) break;
    end
  endtask
  function automatic int find(input logic [7:0] p);
    for (int i = 0; i < 41; i++) if (cap[i +: 8] === p) return i;
    return -1;
  endfunction
  function automatic logic is_sync(input logic [31:0] v);
    logic [7:0] b;
    for (int r = 0; r < 8; r++) begin
      b = (8'h16 >> r) | (8'h16 << (8 - r));
      if (v === {4{b}}) return 1'b1;
    end
    return 1'b0;
  endfunction
  // data bits enter in line order, register shifts toward the top
  function automatic logic [15:0] crc8(input logic [7:0] d, logic [15:0] p);
    logic [15:0] c;
    c = CRC_ZERO;
    for (int i = 0; i < 8; i++) c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? p : 0);
    return c;
  endfunction
  task final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // clock, timeout and test sequence
  // ****************************************
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error timeout");
      final_report;
    end
  end
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, RESET_N, run} = '0;
    {AWADDR, ARADDR, WDATA} = '0;
    ws = 4'h1;
    WSTRB = 4'h1;
    cts_on = 1'b1;
    repeat (20) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    run <= 1'b1;
    // let the clear-to-send synchroniser settle before reading status
    repeat (3) @(posedge REF_CLK);
    rdt(STAT_OFS);
    check("status reset", rd & 32'h66, 32'h64);
    rdt(6'h08);
    check("unmapped resp", rs, RESP_SLVERR);
    check("unmapped data", rd, 32'h0);
    wr(STAT_OFS, 8'h00);
    check("status write", rs, RESP_SLVERR);
    wr(MODE_OFS, 8'h00);
    wr(CMD_OFS, 8'h98);
    wr(SYNL_OFS, 8'h16);
    ws = 4'h0;
    wr(SYNL_OFS, 8'hFF);
    rdt(SYNL_OFS);
    ws = 4'h1;
    check("strobe off", rd, 32'h16);
    bits(12);
    check("idle line", TXD, 1'b1);
    $display("test init done");
    wr(TXCTL_OFS, 8'h6A);
    bits(40);
    check("sync fill", is_sync(cap[63:32]), 1'b1);
    rdt(STAT_OFS);
    check("underrun flag", rd[ST_EOM], 1'b1);
    wr(INTC_OFS, 8'h02);
    wr(DATA_OFS, 8'h4B);
    poll_int;
    check("tx empty int", INT_N, 1'b0);
    wr(CMD_OFS, 8'h28);
    check("pending reset", INT_N, 1'b1);
    bits(48);
    check("no second int", INT_N, 1'b1);
    check("data order", find(8'h4B) >= 0, 1'b1);
    check("underrun syncs", is_sync(cap[63:32]), 1'b1);
    $display("test data done");
    for (int s = 0; s < 2; s++) begin
      wr(INTC_OFS, 8'h01);
      wr(CMD_OFS, 8'h90);
      wr(TXCTL_OFS, s ? 8'h6F : 8'h6B);
      wr(DATA_OFS, 8'h4B);
      wr(CMD_OFS, 8'hC0);
      bits(48);
      k = find(8'h4B);
      cr = {<<{crc8(8'h4B, s ? POLY_CRC16 : POLY_FRAME)}};
      check("crc bits", cap[k + 8 +: 16], cr);
      check("eom int", INT_N, 1'b0);
      rdt(STAT_OFS);
      check("eom flag", rd[ST_EOM], 1'b1);
      wr(CMD_OFS, 8'h10);
      check("ext reset", INT_N, 1'b1);
      bits(16);
    end
    $display("test crc done");
    cts_on <= 1'b0;
    poll_int;
    check("cts change int", INT_N, 1'b0);
    wr(CMD_OFS, 8'h10);
    wr(RXC_OFS, 8'h20);
    bits(20);
    check("cts hold mark", cap[63:56], 8'hFF);
    cts_on <= 1'b1;
    bits(40);
    check("cts resume", is_sync(cap[63:32]), 1'b1);
    $display("test auto enable done");
    // odd parity on a character with four ones gives a one
    wr(MODE_OFS, 8'h01);
    wr(DATA_OFS, 8'h4B);
    bits(40);
    k = find(8'h4B);
    check("parity bit", cap[k + 8], 1'b1);
    $display("test parity done");
    wr(INTC_OFS, 8'hC0);
    check("ready empty", WAIT_READY_N, 1'b0);
    wr(INTC_OFS, 8'h80);
    check("wait empty", WAIT_READY_N, 1'b1);
    wr(TXCTL_OFS, 8'h62);
    wr(DATA_OFS, 8'h4B);
    check("wait full", WAIT_READY_N, 1'b0);
    bits(20);
    check("disabled mark", TXD, 1'b1);
    wr(TXCTL_OFS, 8'h10);
    repeat (2) @(posedge REF_CLK);
    check("break", TXD, 1'b0);
    $display("test line control done");
    final_report;
  end
endmodule
